//--- dv/cor_clock_output_config_regs_bench.sv
`timescale 1ns/10ps
module cor_clock_output_config_regs_bench;
  // ----------------------------------------------------------
  // Signals and bench model
  // ----------------------------------------------------------
  logic        clock = 1'h0;
  logic        rst_b = 1'h0;
  logic        wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
  logic [7:0]  wbAdr = 8'h0;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR, rd;
  logic        wbAck, stepValid, selHigh;
  logic        selLow = 1'h0, clocksActive = 1'h0;
  logic [2:0]  offset, prev;
  logic [19:0] advancePs;
  logic [3:0]  step, lastStep;
  logic [1:0]  corner;
  logic [13:0] cornerMhz;
  logic [4:0]  oeA, oeB;
  logic [7:0]  ctlExp = 8'h0, disAExp = 8'h0, disBExp = 8'h0;  // Expected register bytes
  logic [5:0]  idxTab [5] = '{6'h11, 6'h13, 6'h14, 6'h12, 6'h3f};  // Last two unmapped
  logic [2:0]  offTab [6] = '{3'h2, 3'h1, 3'h1, 3'h7, 3'h0, 3'h7};
  int          fail_count = 0, n_checks = 0, stepCount = 0, n, seed = 32'h31a5;

  always #12.5 clock = ~clock;

  cor_clock_output_config_regs dut_u (
    .clock(clock), .rst_b(rst_b), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .loopFilterSelectLow(selLow), .networkClocksActive(clocksActive),
    .t1ClockPhaseOffset(offset), .t1PhaseAdvancePs(advancePs), .t1PhaseStep(step),
    .t1PhaseStepValid(stepValid), .loopFilterSelectHigh(selHigh), .filterCorner(corner),
    .filterCornerMilliHz(cornerMhz), .clk16mOe(oeA[4]), .clk8mOe(oeA[3]), .clk4mOe(oeA[2]),
    .clk2mOe(oeA[1]), .t1ClockOe(oeA[0]), .frame122Oe(oeB[4]), .frame244Oe(oeB[3]),
    .frame61Oe(oeB[2]), .clk6mOe(oeB[1]), .clk19mOe(oeB[0]));

  // Step pulses last one cycle, so a monitor catches them
  always @(posedge clock) if (stepValid === 1'h1) begin
    stepCount++;
    lastStep = step;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One classic cycle; entered just after a rising edge, leaves one idle cycle
  task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] d,
                      input logic [3:0] sel);
    int k;
    k = 0;
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= {idx, 2'h0};
    wbSel <= sel;
    wbDatW <= {24'($random(seed)), d};
    do begin
      @(posedge clock);
      k++;
    end while (wbAck !== 1'h1 && k < 8);
    rd = wbDatR;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    if (k >= 8) begin
      fail_count++;
      report_and_stop();
    end
    @(posedge clock);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] sel);
    xfer(1'h1, idx, d, sel);
    // Only lane 0 writes land; reserved bits are masked off
    if (sel[0]) begin
      case (idx)
        6'h11: ctlExp = d & 8'h39;
        6'h13: disAExp = d & 8'h3e;
        6'h14: disBExp = d & 8'h1f;
        default: ;
      endcase
    end
  endtask

  function automatic logic [13:0] cornerOf(input logic h, input logic l);
    case ({h, l})
      2'h0: return 14'h05dc;
      2'h1: return 14'h0064;
      2'h2: return 14'h2ee0;
      default: return 14'h1770;
    endcase
  endfunction

  // Outputs at a settled point, then control, both disable registers and one unmapped word read back
  task automatic verify;
    @(negedge clock);
    check("offset", {29'h0, offset}, {29'h0, ctlExp[5:3]});
    check("enables_a", {27'h0, oeA}, {27'h0, ~disAExp[5:1]});
    check("enables_b", {27'h0, oeB}, {27'h0, ~disBExp[4:0]});
    check("corner", {18'h0, cornerMhz}, {18'h0, cornerOf(ctlExp[0], selLow)});
    @(posedge clock);
    xfer(1'h0, 6'h11, 8'h0, 4'hf);
    check("control", rd, {24'h0, ctlExp});
    xfer(1'h0, 6'h13, 8'h0, 4'hf);
    check("disable_a", rd, {24'h0, disAExp});
    xfer(1'h0, 6'h14, 8'h0, 4'hf);
    check("disable_b", rd, {24'h0, disBExp});
    xfer(1'h0, 6'h12, 8'h0, 4'hf);
    check("unmapped", rd, 32'h0);
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'h1;
    repeat (3) @(posedge clock);
    verify();
    $display("test reset values done");
    for (int i = 0; i < 40; i++) begin
      clocksActive <= 1'($random(seed));
      selLow <= 1'($random(seed));
      wr(idxTab[{$random(seed)} % 5], 8'($random(seed)), 4'($random(seed)));
      verify();
    end
    $display("test random writes done");
    // Every corner code, with reserved bits written as ones
    for (int k = 0; k < 4; k++) begin
      selLow <= k[0];
      wr(6'h11, {2'h3, 3'h5, 2'h3, k[1]}, 4'h1);
      verify();
    end
    $display("test filter corners done");
    // phase steps taken with clocks idle, so the sticky warning stays clear
    clocksActive <= 1'h0;
    wr(6'h15, 8'h01, 4'h1);
    prev = ctlExp[5:3];
    for (int k = 0; k < 6; k++) begin
      n = stepCount;
      wr(6'h11, {2'h0, offTab[k], 3'h0}, 4'h1);
      @(negedge clock);
      check("advance", {12'h0, advancePs}, {29'h0, offTab[k]} * 32'h13c40);
      check("steps", 32'(stepCount), 32'(n + int'(offTab[k] != prev)));
      if (offTab[k] != prev) begin
        check("step", {28'h0, lastStep}, {28'h0, {1'h0, offTab[k]} - {1'h0, prev}});
      end
      prev = offTab[k];
      @(posedge clock);
    end
    xfer(1'h0, 6'h15, 8'h0, 4'hf);
    check("status", rd, {28'h0, ctlExp[0], selLow, 2'h0});
    $display("test phase steps done");
    rst_b <= 1'h0;
    @(negedge clock);
    check("reset_enables", {22'h0, oeA, oeB}, 32'h3ff);
    check("reset_offset", {29'h0, offset}, 32'h0);
    repeat (3) @(posedge clock);
    rst_b <= 1'h1;
    repeat (3) @(posedge clock);
    ctlExp = 8'h0;
    disAExp = 8'h0;
    disBExp = 8'h0;
    verify();
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule

//--- dv/cor_clock_output_config_regs_properties.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// Port-level checker for the clock output config registers
// ----------------------------------------------------------
module cor_clock_output_config_regs_checker (
  input logic        clock,
  input logic        rst_b,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [7:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic        loopFilterSelectLow,
  input logic [2:0]  t1ClockPhaseOffset,
  input logic [19:0] t1PhaseAdvancePs,
  input logic [3:0]  t1PhaseStep,
  input logic        t1PhaseStepValid,
  input logic        loopFilterSelectHigh,
  input logic [1:0]  filterCorner,
  input logic [13:0] filterCornerMilliHz,
  input logic        clk16mOe,
  input logic        clk8mOe,
  input logic        clk4mOe,
  input logic        clk2mOe,
  input logic        t1ClockOe,
  input logic        frame122Oe,
  input logic        frame244Oe,
  input logic        frame61Oe,
  input logic        clk6mOe,
  input logic        clk19mOe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Enables grouped in register bit order
  wire [4:0] oeA = {clk16mOe, clk8mOe, clk4mOe, clk2mOe, t1ClockOe};
  wire [4:0] oeB = {frame122Oe, frame244Oe, frame61Oe, clk6mOe, clk19mOe};
  // ----------------------------------------------------------
  // Bus steps: the acked edge is the commit edge
  // ----------------------------------------------------------
  sequence wr_s(idx);
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == idx;
  endsequence
  sequence rd_s(idx);
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == idx;
  endsequence
  ack_answer_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  offset_write_a: assert property (wr_s(6'h11) |=>
    t1ClockPhaseOffset == $past(wb_dat_i[5:3]) && loopFilterSelectHigh == $past(wb_dat_i[0]))
    else $error("control write not applied");
  step_report_a: assert property (wr_s(6'h11) ##0 wb_dat_i[5:3] != t1ClockPhaseOffset |=>
    t1PhaseStepValid &&
    t1PhaseStep == {1'h0, $past(wb_dat_i[5:3])} - {1'h0, $past(t1ClockPhaseOffset)})
    else $error("phase step wrong");
  step_cause_a: assert property (t1PhaseStepValid |-> $past(wb_ack_o && wb_we_i))
    else $error("phase step without a write");
  advance_lag_a: assert property (
    t1PhaseAdvancePs == 20'($past(t1ClockPhaseOffset)) * 20'h13c40)
    else $error("phase advance wrong");
  corner_code_a: assert property (filterCorner ==
    {$past(loopFilterSelectHigh), $past(loopFilterSelectLow)})
    else $error("corner code wrong");
  corner_freq_a: assert property (filterCornerMilliHz == (filterCorner == 2'h0 ? 14'h05dc :
    filterCorner == 2'h1 ? 14'h0064 : filterCorner == 2'h2 ? 14'h2ee0 : 14'h1770))
    else $error("corner frequency wrong");
  oe_a_write_a: assert property (wr_s(6'h13) |=> oeA == ~$past(wb_dat_i[5:1]))
    else $error("clock enables A wrong");
  oe_b_write_a: assert property (wr_s(6'h14) |=> oeB == ~$past(wb_dat_i[4:0]))
    else $error("enables B wrong");
  oe_hold_a: assert property (!(wb_ack_o && wb_we_i) |=> $stable(oeA) && $stable(oeB))
    else $error("enables changed without a write");
  reset_clear_a: assert property ($rose(rst_b) |-> &oeA && &oeB && !loopFilterSelectHigh
    && t1ClockPhaseOffset == 3'h0) else $error("reset state wrong");
  read_ctl_a: assert property (rd_s(6'h11) |-> wb_dat_o ==
    {26'h0, t1ClockPhaseOffset, 2'h0, loopFilterSelectHigh}) else $error("control read wrong");
  read_dis_a: assert property (rd_s(6'h13) |-> wb_dat_o == {26'h0, ~oeA, 1'h0})
    else $error("disable A read wrong");
endmodule

bind cor_clock_output_config_regs cor_clock_output_config_regs_checker chk_u (
  .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .loopFilterSelectLow(loopFilterSelectLow),
  .t1ClockPhaseOffset(t1ClockPhaseOffset), .t1PhaseAdvancePs(t1PhaseAdvancePs),
  .t1PhaseStep(t1PhaseStep), .t1PhaseStepValid(t1PhaseStepValid),
  .loopFilterSelectHigh(loopFilterSelectHigh), .filterCorner(filterCorner),
  .filterCornerMilliHz(filterCornerMilliHz), .clk16mOe(clk16mOe), .clk8mOe(clk8mOe),
  .clk4mOe(clk4mOe), .clk2mOe(clk2mOe), .t1ClockOe(t1ClockOe), .frame122Oe(frame122Oe),
  .frame244Oe(frame244Oe), .frame61Oe(frame61Oe), .clk6mOe(clk6mOe), .clk19mOe(clk19mOe));

//--- hdl/cor_clock_output_config_regs.sv
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps

module cor_clock_output_config_regs (
  input  wire logic        clock,                // 40 MHz device clock
  input  wire logic        rst_b,                // Asynchronous reset, active low
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,             // Bus cycle
  input  wire logic        wb_stb_i,             // Strobe
  input  wire logic        wb_we_i,              // Write enable
  input  wire logic [7:0]  wb_adr_i,             // Byte address
  input  wire logic [3:0]  wb_sel_i,             // Byte lane selects
  input  wire logic [31:0] wb_dat_i,             // Write data
  output logic      [31:0] wb_dat_o,             // Read data
  output logic             wb_ack_o,             // Acknowledge
  // Device side
  input  wire logic        loopFilterSelectLow,  // Companion filter bit
  input  wire logic        networkClocksActive,  // PLL is producing clocks
  output logic      [2:0]  t1ClockPhaseOffset,   // Current phase offset
  output logic      [19:0] t1PhaseAdvancePs,     // Offset times step, picoseconds
  output logic      [3:0]  t1PhaseStep,          // Signed change, new minus old
  output logic             t1PhaseStepValid,     // One-cycle pulse with step
  output logic             loopFilterSelectHigh, // Second filter select bit
  output logic      [1:0]  filterCorner,         // Corner code
  output logic      [13:0] filterCornerMilliHz,  // Corner in millihertz
  output logic             clk16mOe,             // Drive enables, high drives
  output logic             clk8mOe,
  output logic             clk4mOe,
  output logic             clk2mOe,
  output logic             t1ClockOe,
  output logic             frame122Oe,
  output logic             frame244Oe,
  output logic             frame61Oe,
  output logic             clk6mOe,
  output logic             clk19mOe
);

  // ---------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------

  logic [cor_pkg::RESET_SYNC_STAGES-1:0] rstSync_q;  // Release shift chain
  logic                                  rstSync_b;  // Synchronised reset

  // Assert at once, release two edges later so no flop sees a runt release
  // Only this chain reads the raw pin; every other reset flop uses the copy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_q <= '0;
    end else begin
      rstSync_q <= {rstSync_q[cor_pkg::RESET_SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rstSync_b = rstSync_q[cor_pkg::RESET_SYNC_STAGES-1];

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------

  logic       busReq;        // Live request
  logic       busAccept;     // Edge at which the master samples ack
  logic [5:0] regIdx;        // Word index
  logic       selCtrl;       // Phase and filter control
  logic       selDisA;       // Clock output disable A
  logic       selDisB;       // Clock output disable B
  logic       selStat;       // Phase change status
  logic       wrLane0;       // Write with lane 0 enabled

  assign busReq    = wb_cyc_i & wb_stb_i;
  // Writes commit only on the edge that the master takes ack
  assign busAccept = busReq & wb_ack_o;
  assign regIdx    = wb_adr_i[7:2];
  assign selCtrl   = (regIdx == cor_pkg::PHASE_AND_FILTER_CONTROL_IDX);
  assign selDisA   = (regIdx == cor_pkg::CLOCK_OUTPUT_DISABLE_A_IDX);
  assign selDisB   = (regIdx == cor_pkg::CLOCK_OUTPUT_DISABLE_B_IDX);
  assign selStat   = (regIdx == cor_pkg::PHASE_CHANGE_STATUS_IDX);
  // Registers are eight bits wide and live in lane 0 only
  assign wrLane0   = busAccept & wb_we_i & wb_sel_i[0];

  // ---------------------------------------------------------------------
  // Acknowledge
  // ---------------------------------------------------------------------

  // One wait state; ack drops by itself the cycle after it is given,
  // so a held request never sees a second ack on the same edge.
  // Unmapped addresses are acked too and read as zero.
  // A master that holds cyc and stb past ack is served again two cycles
  // on, so it must drop them for a cycle between accesses.
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
    end
  end

  // ---------------------------------------------------------------------
  // Phase and filter control register
  // ---------------------------------------------------------------------

  logic [7:0] ctrl_q;        // Stored control, reserved bits held at zero
  logic [7:0] ctrl_d;        // Masked write value
  logic       ctrlWr;        // Write strobe

  assign ctrlWr = wrLane0 & selCtrl;
  assign ctrl_d = wb_dat_i[7:0] & cor_pkg::PHASE_AND_FILTER_CONTROL_MASK;

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ctrl_q <= cor_pkg::PHASE_AND_FILTER_CONTROL_RST;
    end else if (ctrlWr) begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------------
  // Clock output disable registers
  // ---------------------------------------------------------------------

  logic [7:0] disA_q;        // Five clock disables
  logic [7:0] disB_q;        // Frame, 6M and 19M disables

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      disA_q <= cor_pkg::CLOCK_OUTPUT_DISABLE_A_RST;
    end else if (wrLane0 & selDisA) begin
      disA_q <= wb_dat_i[7:0] & cor_pkg::CLOCK_OUTPUT_DISABLE_A_MASK;
    end
  end

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      disB_q <= cor_pkg::CLOCK_OUTPUT_DISABLE_B_RST;
    end else if (wrLane0 & selDisB) begin
      disB_q <= wb_dat_i[7:0] & cor_pkg::CLOCK_OUTPUT_DISABLE_B_MASK;
    end
  end

  // ---------------------------------------------------------------------
  // Phase offset value and step report
  // ---------------------------------------------------------------------

  logic [2:0]  newOffset;    // Offset carried by the write under way
  logic [3:0]  stepDelta;    // Signed difference, new minus current
  logic [3:0]  step_q;       // Registered step
  logic        stepValid_q;  // Registered step strobe
  logic [19:0] advance_q;    // Registered advance in picoseconds

  assign t1ClockPhaseOffset = ctrl_q[cor_pkg::T1_CLOCK_PHASE_OFFSET_LSB +:
                                     cor_pkg::T1_CLOCK_PHASE_OFFSET_W];
  assign newOffset = ctrl_d[cor_pkg::T1_CLOCK_PHASE_OFFSET_LSB +:
                            cor_pkg::T1_CLOCK_PHASE_OFFSET_W];
  assign stepDelta = {1'b0, newOffset} - {1'b0, t1ClockPhaseOffset};

  // The PLL moves the clock by the step; a write of the same value is silent
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      step_q      <= 4'h0;
      stepValid_q <= 1'b0;
    end else begin
      stepValid_q <= ctrlWr & (newOffset != t1ClockPhaseOffset);
      if (ctrlWr) begin
        step_q <= stepDelta;
      end
    end
  end

  // offset times step
  // Follows the stored offset one cycle later; product fits 20 bits
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      advance_q <= 20'h00000;
    end else begin
      advance_q <= 20'(32'(t1ClockPhaseOffset) * cor_pkg::T1_PHASE_STEP_PS);
    end
  end

  assign t1PhaseStep      = step_q;
  assign t1PhaseStepValid = stepValid_q;
  assign t1PhaseAdvancePs = advance_q;

  // ---------------------------------------------------------------------
  // Phase change warning
  // ---------------------------------------------------------------------

  logic phaseWarn_q;         // Sticky: offset changed while clocks active
  logic phaseWarnSet;        // Set event
  logic phaseWarnClr;        // Write-one clear

  // flags risky change
  // Nothing is blocked; software is only told the clocks may have glitched
  assign phaseWarnSet = ctrlWr & (newOffset != t1ClockPhaseOffset) & networkClocksActive;
  assign phaseWarnClr = wrLane0 & selStat & wb_dat_i[cor_pkg::STATUS_PHASE_WARN];

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      phaseWarn_q <= 1'b0;
    end else if (phaseWarnSet) begin
      phaseWarn_q <= 1'b1;
    end else if (phaseWarnClr) begin
      phaseWarn_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Loop filter corner
  // ---------------------------------------------------------------------

  cor_pkg::cor_corner_t corner;     // Decoded corner
  logic [13:0]          cornerMhz;  // Corner in millihertz

  assign loopFilterSelectHigh = ctrl_q[cor_pkg::LOOP_FILTER_SELECT_HIGH];

  // Combines this block's bit with the companion bit held elsewhere
  always_comb begin
    case ({loopFilterSelectHigh, loopFilterSelectLow})
      2'h0: begin
        corner    = cor_pkg::COR_CORNER_1P5HZ;
        cornerMhz = cor_pkg::CORNER_1P5HZ_MHZ;
      end
      2'h1: begin
        corner    = cor_pkg::COR_CORNER_0P1HZ;
        cornerMhz = cor_pkg::CORNER_0P1HZ_MHZ;
      end
      2'h2: begin
        corner    = cor_pkg::COR_CORNER_12HZ;
        cornerMhz = cor_pkg::CORNER_12HZ_MHZ;
      end
      2'h3: begin
        corner    = cor_pkg::COR_CORNER_6HZ;
        cornerMhz = cor_pkg::CORNER_6HZ_MHZ;
      end
      default: begin
        corner    = cor_pkg::COR_CORNER_1P5HZ;
        cornerMhz = cor_pkg::CORNER_1P5HZ_MHZ;
      end
    endcase
  end

  logic [1:0]  cornerCode_q;  // Registered corner code
  logic [13:0] cornerMhz_q;   // Registered corner in millihertz

  // Registered so the outputs carry no decode glitches; no reset, so the
  // copy keeps following the companion bit while reset is held
  always_ff @(posedge clock) begin
    cornerCode_q <= corner;
    cornerMhz_q  <= cornerMhz;
  end

  assign filterCorner        = cornerCode_q;
  assign filterCornerMilliHz = cornerMhz_q;

  // ---------------------------------------------------------------------
  // Output drive enables
  // ---------------------------------------------------------------------

  // Enables come straight from register flops, high while the pin drives
  // 16M float
  assign clk16mOe   = ~disA_q[cor_pkg::CLK16M_OUTPUT_OFF];
  assign clk8mOe    = ~disA_q[cor_pkg::CLK8M_OUTPUT_OFF];
  assign clk4mOe    = ~disA_q[cor_pkg::CLK4M_OUTPUT_OFF];
  assign clk2mOe    = ~disA_q[cor_pkg::CLK2M_OUTPUT_OFF];
  assign t1ClockOe  = ~disA_q[cor_pkg::T1_CLOCK_OUTPUT_OFF];
  assign frame122Oe = ~disB_q[cor_pkg::FRAME_PULSE_122NS_OFF];
  assign frame244Oe = ~disB_q[cor_pkg::FRAME_PULSE_244NS_OFF];
  assign frame61Oe  = ~disB_q[cor_pkg::FRAME_PULSE_61NS_OFF];
  assign clk6mOe    = ~disB_q[cor_pkg::CLK6M_OUTPUT_OFF];
  assign clk19mOe   = ~disB_q[cor_pkg::CLK19M_OUTPUT_OFF];

  // ---------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------

  logic [7:0] rdByte;        // Selected register, low byte

  // Status shows the sticky warning, live activity and the corner code
  always_comb begin
    rdByte = 8'h00;
    if (selCtrl) begin
      rdByte = ctrl_q;
    end else if (selDisA) begin
      rdByte = disA_q;
    end else if (selDisB) begin
      rdByte = disB_q;
    end else if (selStat) begin
      rdByte[cor_pkg::STATUS_PHASE_WARN]        = phaseWarn_q;
      rdByte[cor_pkg::STATUS_CLOCKS_ACTIVE]     = networkClocksActive;
      rdByte[cor_pkg::STATUS_CORNER_LSB +: 2]   = corner;
    end else begin
      rdByte = 8'h00;  // Unmapped word reads as zero
    end
  end

  // Captured with ack so data and ack stand together for the one cycle
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      wb_dat_o <= 32'h00000000;
    end else if (busReq & ~wb_ack_o) begin
      wb_dat_o <= {24'h000000, rdByte};
    end
  end

endmodule

//--- shared/cor_pkg.sv
// ---------------------------------------------------------------------
// Clock output configuration registers: shared constants
// ---------------------------------------------------------------------
package cor_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [5:0] PHASE_AND_FILTER_CONTROL_IDX = 6'h11;  // Phase offset, filter bit
  localparam logic [5:0] CLOCK_OUTPUT_DISABLE_A_IDX   = 6'h13;  // Five clock disables
  localparam logic [5:0] CLOCK_OUTPUT_DISABLE_B_IDX   = 6'h14;  // Frames, 6M, 19M disables
  localparam logic [5:0] PHASE_CHANGE_STATUS_IDX      = 6'h15;  // Sticky warning, status

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] PHASE_AND_FILTER_CONTROL_RST = 8'h00;
  localparam logic [7:0] CLOCK_OUTPUT_DISABLE_A_RST   = 8'h00;
  localparam logic [7:0] CLOCK_OUTPUT_DISABLE_B_RST   = 8'h00;

  // ---------------------------------------------------------------------
  // Implemented-bit masks; all other bits are reserved
  // ---------------------------------------------------------------------
  localparam logic [7:0] PHASE_AND_FILTER_CONTROL_MASK = 8'h39;
  localparam logic [7:0] CLOCK_OUTPUT_DISABLE_A_MASK   = 8'h3e;
  localparam logic [7:0] CLOCK_OUTPUT_DISABLE_B_MASK   = 8'h1f;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int T1_CLOCK_PHASE_OFFSET_LSB  = 3;  // Three bits, 5 down to 3
  localparam int T1_CLOCK_PHASE_OFFSET_W    = 3;
  localparam int LOOP_FILTER_SELECT_HIGH    = 0;
  localparam int CLK16M_OUTPUT_OFF          = 5;
  localparam int CLK8M_OUTPUT_OFF           = 4;
  localparam int CLK4M_OUTPUT_OFF           = 3;
  localparam int CLK2M_OUTPUT_OFF           = 2;
  localparam int T1_CLOCK_OUTPUT_OFF        = 1;
  localparam int FRAME_PULSE_122NS_OFF      = 4;
  localparam int FRAME_PULSE_244NS_OFF      = 3;
  localparam int FRAME_PULSE_61NS_OFF       = 2;
  localparam int CLK6M_OUTPUT_OFF           = 1;
  localparam int CLK19M_OUTPUT_OFF          = 0;
  localparam int STATUS_PHASE_WARN          = 0;  // Sticky, write one to clear
  localparam int STATUS_CLOCKS_ACTIVE       = 1;  // Live copy of the activity input
  localparam int STATUS_CORNER_LSB          = 2;  // Two-bit corner code

  // ---------------------------------------------------------------------
  // Timing figures
  // ---------------------------------------------------------------------
  localparam int T1_PHASE_STEP_PS = 80960;  // Advance per unit of phase offset
  localparam int RESET_SYNC_STAGES = 2;

  // ---------------------------------------------------------------------
  // Loop filter corner selection
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    COR_CORNER_1P5HZ = 2'h0,
    COR_CORNER_0P1HZ = 2'h1,
    COR_CORNER_12HZ  = 2'h2,
    COR_CORNER_6HZ   = 2'h3
  } cor_corner_t;

  localparam logic [13:0] CORNER_1P5HZ_MHZ = 14'h05dc;  // 1500 mHz
  localparam logic [13:0] CORNER_0P1HZ_MHZ = 14'h0064;  // 100 mHz
  localparam logic [13:0] CORNER_12HZ_MHZ  = 14'h2ee0;  // 12000 mHz
  localparam logic [13:0] CORNER_6HZ_MHZ   = 14'h1770;  // 6000 mHz

endpackage
